// *** logic/rsse_pkg.sv ***
package rsse_pkg;

  localparam int NUM_TS = 32;
  localparam int TS_W = 5;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 32;
  localparam int IDX_W = 11;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] CTRL_IDX = 11'h3A0;
  localparam logic [IDX_W-1:0] SUBST_IDX = 11'h3C0;
  localparam logic [IDX_W-1:0] GLOBAL_IDX = 11'h3E0;
  localparam logic [IDX_W-1:0] ARRAY_IDX = 11'h500;

  // Control register fields
  localparam int CTRL_SUBST_EN_BIT = 6;
  localparam int CTRL_OH_EN_BIT = 5;
  localparam int CTRL_DEB_EN_BIT = 4;
  localparam int CTRL_SUBFMT_LSB = 2;
  localparam int CTRL_EXTFMT_LSB = 0;
  localparam logic [7:0] CTRL_MASK = 8'h7F;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Substitute value fields
  localparam int TWO_CODE_A_BIT = 6;
  localparam int FOUR_CODE_B_BIT = 5;
  localparam int FOUR_CODE_A_BIT = 4;
  localparam int SIXTEEN_CODE_D_BIT = 3;
  localparam int SIXTEEN_CODE_C_BIT = 2;
  localparam int SIXTEEN_CODE_B_BIT = 1;
  localparam int SIXTEEN_CODE_A_BIT = 0;
  localparam logic [7:0] SUBST_MASK = 8'h7F;
  localparam logic [7:0] SUBST_RST = 8'h00;

  // Signaling nibble layout, as in the array: A high, D low
  localparam int SIG_A_BIT = 3;
  localparam int SIG_B_BIT = 2;
  localparam int SIG_C_BIT = 1;
  localparam int SIG_D_BIT = 0;
  localparam logic [3:0] ARRAY_RST = 4'h0;

  // Global control
  localparam int GLOBAL_SIG_IF_EN_BIT = 0;
  localparam logic [7:0] GLOBAL_MASK = 8'h01;
  localparam logic [7:0] GLOBAL_RST = 8'h00;

  // Debounce needs this many equal superframes in a row
  localparam int DEB_SUPERFRAMES = 2;

  typedef enum logic [1:0] {RSSE_SUB_ONES, RSSE_SUB_16, RSSE_SUB_4, RSSE_SUB_2} rsse_sub_fmt_e;
  typedef enum logic [1:0] {RSSE_EXT_NONE, RSSE_EXT_ABCD, RSSE_EXT_AB, RSSE_EXT_A} rsse_ext_fmt_e;

endpackage

// *** logic/rsse_sig_debounce.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsse_sig_debounce
#(
  parameter int DEB_COUNT = rsse_pkg::DEB_SUPERFRAMES
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Superframe sample of the extracted nibble
  input wire logic sample_valid,
  input wire logic [3:0] sample,
  input wire logic deb_en,
  // Settled state
  output logic [3:0] value,
  output logic updated
);
  import rsse_pkg::*;

  logic [3:0] last;
  logic [1:0] stable_cnt;
  logic [1:0] next_cnt;
  logic take;

  // Count of consecutive superframes with the same nibble, saturating
  always_comb
  begin
    next_cnt = 2'd1;
    if (sample == last && stable_cnt != 2'd3)
    begin
      next_cnt = 2'(stable_cnt + 2'd1);
    end
    else if (sample == last)
    begin
      next_cnt = stable_cnt;
    end
  end

  assign take = sample_valid && sample != value &&
    (!deb_en || int'(next_cnt) >= DEB_COUNT);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last <= ARRAY_RST;
      stable_cnt <= 2'd0;
    end
    else if (sample_valid)
    begin
      last <= sample;
      stable_cnt <= next_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value <= ARRAY_RST;
      updated <= 1'b0;
    end
    else
    begin
      updated <= take;
      if (take)
      begin
        value <= sample;
      end
    end
  end

endmodule
`default_nettype wire

// *** logic/rsse_top.sv ***
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module rsse_top
#(
  parameter int NTS = rsse_pkg::NUM_TS
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rsse_pkg::ADDR_W-1:0] paddr,
  input wire logic [rsse_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [rsse_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received timeslot stream from the framer
  input wire logic in_valid,
  input wire logic [rsse_pkg::TS_W-1:0] in_ts,
  input wire logic [7:0] in_octet,
  input wire logic [3:0] in_abcd,
  input wire logic in_sf_sample,
  // Outgoing receive PCM stream
  output logic rx_pcm_serial_out_valid,
  output logic [rsse_pkg::TS_W-1:0] rx_pcm_serial_out_ts,
  output logic [7:0] rx_pcm_serial_out,
  output logic [3:0] rx_pcm_serial_out_abcd,
  // Signaling pin output
  output logic rx_signaling_out_valid,
  output logic [rsse_pkg::TS_W-1:0] rx_signaling_out_ts,
  output logic [3:0] rx_signaling_out_pin,
  // Overhead output
  output logic rx_overhead_out_valid,
  output logic [rsse_pkg::TS_W-1:0] rx_overhead_out_ts,
  output logic [3:0] rx_overhead_out_pin
);
  import rsse_pkg::*;

  // Register storage, one entry per timeslot except the single global control register
  logic [7:0] rx_signaling_control [NTS];
  logic [7:0] rx_signaling_substitute_value [NTS];
  logic [7:0] global_control;
  logic [3:0] rx_signaling_array [NTS];
  logic [NTS-1:0] array_updated;

  // Bus decode
  logic [IDX_W-1:0] reg_idx;
  logic [5:0] reg_group;
  logic [TS_W-1:0] reg_ts;
  logic hit_ctrl;
  logic hit_subst;
  logic hit_global;
  logic hit_array;
  logic hit_any;
  logic wr_en;
  logic rd_setup;
  logic [DATA_W-1:0] next_prdata;

  assign reg_idx = paddr[ADDR_W-1:2];
  assign reg_group = reg_idx[IDX_W-1:TS_W];
  assign reg_ts = reg_idx[TS_W-1:0];

  // Every block is 32-aligned, so the low index bits give the timeslot
  always_comb
  begin
    hit_ctrl = 1'b0;
    hit_subst = 1'b0;
    hit_global = 1'b0;
    hit_array = 1'b0;
    if (paddr[1:0] == 2'b00)
    begin
      hit_ctrl = reg_group == CTRL_IDX[IDX_W-1:TS_W] && int'(reg_ts) < NTS;
      hit_subst = reg_group == SUBST_IDX[IDX_W-1:TS_W] && int'(reg_ts) < NTS;
      hit_global = reg_idx == GLOBAL_IDX;
      hit_array = reg_group == ARRAY_IDX[IDX_W-1:TS_W] && int'(reg_ts) < NTS;
    end
  end

  assign hit_any = hit_ctrl || hit_subst || hit_global || hit_array;
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_setup = psel && !penable;
  assign pready = psel && penable;

  // Configuration writes; the array is read only and ignores writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NTS; i++)
      begin
        rx_signaling_control[i] <= CTRL_RST;
      end
    end
    else if (wr_en && hit_ctrl)
    begin
      rx_signaling_control[reg_ts] <= pwdata[7:0] & CTRL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NTS; i++)
      begin
        rx_signaling_substitute_value[i] <= SUBST_RST;
      end
    end
    else if (wr_en && hit_subst)
    begin
      rx_signaling_substitute_value[reg_ts] <= pwdata[7:0] & SUBST_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_control <= GLOBAL_RST;
    end
    else if (wr_en && hit_global)
    begin
      global_control <= pwdata[7:0] & GLOBAL_MASK;
    end
  end

  // Read data is captured in the setup cycle so it is stable for the whole access
  always_comb
  begin
    next_prdata = '0;
    if (hit_ctrl)
    begin
      next_prdata[7:0] = rx_signaling_control[reg_ts];
    end
    else if (hit_subst)
    begin
      next_prdata[7:0] = rx_signaling_substitute_value[reg_ts];
    end
    else if (hit_global)
    begin
      next_prdata[7:0] = global_control;
    end
    else if (hit_array)
    begin
      next_prdata[3:0] = rx_signaling_array[reg_ts];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata <= pwrite ? '0 : next_prdata;
      pslverr <= !hit_any;
    end
  end

  // Settings of the timeslot now on the stream
  logic [7:0] cur_ctrl;
  logic [7:0] cur_subst;
  rsse_sub_fmt_e cur_sub_fmt;
  rsse_ext_fmt_e cur_ext_fmt;
  logic cur_subst_en;
  logic [3:0] next_pcm_abcd;
  logic [3:0] ext_abcd;
  logic ext_strobe;

  assign cur_ctrl = rx_signaling_control[in_ts];
  assign cur_subst = rx_signaling_substitute_value[in_ts];
  assign cur_sub_fmt = rsse_sub_fmt_e'(cur_ctrl[CTRL_SUBFMT_LSB +: 2]);
  assign cur_ext_fmt = rsse_ext_fmt_e'(cur_ctrl[CTRL_EXTFMT_LSB +: 2]);
  assign cur_subst_en = cur_ctrl[CTRL_SUBST_EN_BIT];

  // Substitution acts on the PCM copy only; extraction below sees raw bits
  always_comb
  begin
    next_pcm_abcd = in_abcd;
    if (cur_subst_en)
    begin
      unique case (cur_sub_fmt)
        RSSE_SUB_ONES:
        begin
          next_pcm_abcd = 4'hF;
        end
        RSSE_SUB_16:
        begin
          next_pcm_abcd[SIG_A_BIT] = cur_subst[SIXTEEN_CODE_A_BIT];
          next_pcm_abcd[SIG_B_BIT] = cur_subst[SIXTEEN_CODE_B_BIT];
          next_pcm_abcd[SIG_C_BIT] = cur_subst[SIXTEEN_CODE_C_BIT];
          next_pcm_abcd[SIG_D_BIT] = cur_subst[SIXTEEN_CODE_D_BIT];
        end
        RSSE_SUB_4:
        begin
          next_pcm_abcd[SIG_A_BIT] = cur_subst[FOUR_CODE_A_BIT];
          next_pcm_abcd[SIG_B_BIT] = cur_subst[FOUR_CODE_B_BIT];
        end
        RSSE_SUB_2:
        begin
          next_pcm_abcd[SIG_A_BIT] = cur_subst[TWO_CODE_A_BIT];
        end
      endcase
    end
  end

  // Bits outside the chosen code read as zero
  always_comb
  begin
    ext_abcd = 4'h0;
    unique case (cur_ext_fmt)
      RSSE_EXT_NONE:
      begin
        ext_abcd = 4'h0;
      end
      RSSE_EXT_ABCD:
      begin
        ext_abcd = in_abcd;
      end
      RSSE_EXT_AB:
      begin
        ext_abcd[SIG_A_BIT] = in_abcd[SIG_A_BIT];
        ext_abcd[SIG_B_BIT] = in_abcd[SIG_B_BIT];
      end
      RSSE_EXT_A:
      begin
        ext_abcd[SIG_A_BIT] = in_abcd[SIG_A_BIT];
      end
    endcase
  end

  assign ext_strobe = in_valid && in_sf_sample && cur_ext_fmt != RSSE_EXT_NONE;

  // Outgoing PCM: one cycle of latency, octet untouched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_pcm_serial_out_valid <= 1'b0;
      rx_pcm_serial_out_ts <= '0;
      rx_pcm_serial_out <= 8'h00;
      rx_pcm_serial_out_abcd <= 4'h0;
    end
    else
    begin
      rx_pcm_serial_out_valid <= in_valid;
      if (in_valid)
      begin
        rx_pcm_serial_out_ts <= in_ts;
        rx_pcm_serial_out <= in_octet;
        rx_pcm_serial_out_abcd <= next_pcm_abcd;
      end
    end
  end

  // One settling stage per timeslot feeds the array
  genvar g;
  generate
    for (g = 0; g < NTS; g++)
    begin : gen_ts
      rsse_sig_debounce #(
        .DEB_COUNT(DEB_SUPERFRAMES)
      ) u_deb (
        .pclk(pclk),
        .presetn(presetn),
        .sample_valid(ext_strobe && int'(in_ts) == g),
        .sample(ext_abcd),
        .deb_en(rx_signaling_control[g][CTRL_DEB_EN_BIT]),
        .value(rx_signaling_array[g]),
        .updated(array_updated[g])
      );
    end
  endgenerate

  // Remember which timeslot was sampled, to read its settled value a cycle later
  logic d1_valid;
  logic [TS_W-1:0] d1_ts;
  logic d1_oh_en;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      d1_valid <= 1'b0;
      d1_ts <= '0;
      d1_oh_en <= 1'b0;
    end
    else
    begin
      d1_valid <= ext_strobe;
      if (ext_strobe)
      begin
        d1_ts <= in_ts;
        d1_oh_en <= cur_ctrl[CTRL_OH_EN_BIT];
      end
    end
  end

  // Pin carries only real changes, so downstream sees the settled state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_signaling_out_valid <= 1'b0;
      rx_signaling_out_ts <= '0;
      rx_signaling_out_pin <= 4'h0;
    end
    else
    begin
      rx_signaling_out_valid <= 1'b0;
      if (d1_valid && array_updated[d1_ts] && global_control[GLOBAL_SIG_IF_EN_BIT])
      begin
        rx_signaling_out_valid <= 1'b1;
        rx_signaling_out_ts <= d1_ts;
        rx_signaling_out_pin <= rx_signaling_array[d1_ts];
      end
    end
  end

  // Overhead repeats the array content on every extracted superframe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_overhead_out_valid <= 1'b0;
      rx_overhead_out_ts <= '0;
      rx_overhead_out_pin <= 4'h0;
    end
    else
    begin
      rx_overhead_out_valid <= 1'b0;
      if (d1_valid && d1_oh_en)
      begin
        rx_overhead_out_valid <= 1'b1;
        rx_overhead_out_ts <= d1_ts;
        rx_overhead_out_pin <= rx_signaling_array[d1_ts];
      end
    end
  end

endmodule
`default_nettype wire

// *** sim/rsse_backplane_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsse_backplane_model
  import rsse_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Signaling and overhead streams
  input wire logic rx_signaling_out_valid,
  input wire logic [rsse_pkg::TS_W-1:0] rx_signaling_out_ts,
  input wire logic [3:0] rx_signaling_out_pin,
  input wire logic rx_overhead_out_valid,
  input wire logic [rsse_pkg::TS_W-1:0] rx_overhead_out_ts,
  input wire logic [3:0] rx_overhead_out_pin
);
  logic [3:0] sig_val;
  logic [TS_W-1:0] sig_ts;
  int sig_cnt;
  logic [3:0] oh_val;
  logic [TS_W-1:0] oh_ts;
  int oh_cnt;
  // Values are taken only on a pulse; data between pulses is not trusted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sig_val <= 4'h0;
      sig_ts <= '0;
      sig_cnt <= 0;
      oh_val <= 4'h0;
      oh_ts <= '0;
      oh_cnt <= 0;
    end
    else
    begin
      if (rx_signaling_out_valid)
      begin
        sig_val <= rx_signaling_out_pin;
        sig_ts <= rx_signaling_out_ts;
        sig_cnt <= sig_cnt + 1;
      end
      if (rx_overhead_out_valid)
      begin
        oh_val <= rx_overhead_out_pin;
        oh_ts <= rx_overhead_out_ts;
        oh_cnt <= oh_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/rsse_top_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsse_top_assertions
  import rsse_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [rsse_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Stream in
  input wire logic in_valid,
  input wire logic [rsse_pkg::TS_W-1:0] in_ts,
  input wire logic [7:0] in_octet,
  input wire logic in_sf_sample,
  // Stream out
  input wire logic rx_pcm_serial_out_valid,
  input wire logic [rsse_pkg::TS_W-1:0] rx_pcm_serial_out_ts,
  input wire logic [7:0] rx_pcm_serial_out,
  input wire logic rx_signaling_out_valid,
  input wire logic [3:0] rx_signaling_out_pin,
  input wire logic rx_overhead_out_valid,
  input wire logic [rsse_pkg::TS_W-1:0] rx_overhead_out_ts,
  input wire logic [3:0] rx_overhead_out_pin
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_sampled;
    in_valid && in_sf_sample;
  endsequence
  sequence s_oh_late;
    s_sampled ##2 rx_overhead_out_valid;
  endsequence
  sequence s_both_pulse;
    rx_signaling_out_valid && rx_overhead_out_valid;
  endsequence
  // Aligned access into the control or substitute block, every timeslot of which is mapped
  sequence s_cfg_access;
    psel && penable && paddr[1:0] == 2'h0 &&
      (paddr[ADDR_W-1:TS_W+2] == CTRL_IDX[IDX_W-1:TS_W] ||
      paddr[ADDR_W-1:TS_W+2] == SUBST_IDX[IDX_W-1:TS_W]);
  endsequence
  a_mapped_ok: assert property (s_cfg_access |-> !pslverr)
    else $error("mapped register refused");
  a_pcm_follows: assert property (in_valid |=> rx_pcm_serial_out_valid)
    else $error("pcm valid missing");
  a_pcm_no_extra: assert property (rx_pcm_serial_out_valid |-> $past(in_valid))
    else $error("pcm valid without input");
  a_pcm_ts_kept: assert property (in_valid |=> rx_pcm_serial_out_ts == $past(in_ts))
    else $error("pcm timeslot wrong");
  a_octet_kept: assert property (in_valid |=> rx_pcm_serial_out == $past(in_octet))
    else $error("pcm octet altered");
  a_apb_ready: assert property (s_setup ##1 (psel && penable) |-> pready)
    else $error("no ready in access");
  a_unaligned_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access accepted");
  a_sig_after: assert property (rx_signaling_out_valid |->
    $past(in_valid && in_sf_sample, 2))
    else $error("signaling pulse without sample");
  a_oh_after: assert property (rx_overhead_out_valid |->
    $past(in_valid && in_sf_sample, 2))
    else $error("overhead pulse without sample");
  a_oh_ts_kept: assert property (s_oh_late |-> rx_overhead_out_ts == $past(in_ts, 2))
    else $error("overhead timeslot wrong");
  a_pins_agree: assert property (s_both_pulse |->
    rx_signaling_out_pin == rx_overhead_out_pin)
    else $error("signaling and overhead differ");
endmodule
bind rsse_top rsse_top_assertions chk (.*);
`default_nettype wire

// *** sim/rx_signaling_substitution_extraction_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module rx_signaling_substitution_extraction_test;
  import rsse_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, err;
  logic [DATA_W-1:0] rd;
  logic in_valid = 0;
  logic in_sf_sample = 0;
  logic [TS_W-1:0] in_ts = '0;
  logic [7:0] in_octet = '0;
  logic [3:0] in_abcd = '0;
  logic rx_pcm_serial_out_valid, rx_signaling_out_valid, rx_overhead_out_valid;
  logic [TS_W-1:0] rx_pcm_serial_out_ts, rx_signaling_out_ts, rx_overhead_out_ts;
  logic [7:0] rx_pcm_serial_out;
  logic [3:0] rx_pcm_serial_out_abcd, rx_signaling_out_pin, rx_overhead_out_pin;
  int fail_count = 0;
  int checks_done = 0;
  always #25 pclk = ~pclk;
  rsse_top dut (.*);
  rsse_backplane_model bp (.*);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] d);
    int n;
    logic seen;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    seen = pready;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (seen !== 1'b1)
    begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic send(input int t, input logic [3:0] s, input logic sf);
    @(posedge pclk);
    in_valid <= 1'b1;
    in_ts <= TS_W'(t);
    in_abcd <= s;
    in_sf_sample <= sf;
    in_octet <= 8'(t) ^ 8'hA5;
    @(posedge pclk);
    in_valid <= 1'b0;
    #1;
  endtask
  // Signaling reaches the backplane two edges after the sample
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic t_regs();
    apb(0, {CTRL_IDX, 2'h0}, 0);
    chk("ctrl0 reset", 0, rd);
    chk("mapped err", 0, err);
    apb(0, {SUBST_IDX + 11'h1F, 2'h0}, 0);
    chk("subst31 reset", 0, rd);
    apb(1, {CTRL_IDX + 11'h1F, 2'h0}, 32'hFF);
    apb(0, {CTRL_IDX + 11'h1F, 2'h0}, 0);
    chk("ctrl31", 32'h7F, rd);
    pstrb <= 4'hE;
    apb(1, {CTRL_IDX + 11'h1F, 2'h0}, 32'h00);
    pstrb <= 4'hF;
    apb(0, {CTRL_IDX + 11'h1F, 2'h0}, 0);
    chk("ctrl31 lane off", 32'h7F, rd);
    apb(1, {SUBST_IDX + 11'h1F, 2'h0}, 32'h2A);
    apb(1, {SUBST_IDX, 2'h0}, 32'h55);
    apb(0, {SUBST_IDX + 11'h1F, 2'h0}, 0);
    chk("subst31", 32'h2A, rd);
    apb(0, {SUBST_IDX, 2'h0}, 0);
    chk("subst0", 32'h55, rd);
    apb(0, 13'h1001, 0);
    chk("unaligned err", 1, err);
    apb(0, 13'h1000, 0);
    chk("unmapped err", 1, err);
  endtask
  task automatic t_subst();
    logic [3:0] exp [4] = '{4'hF, 4'h5, 4'h8, 4'h4};
    apb(1, {SUBST_IDX + 11'h5, 2'h0}, 32'h1A);
    for (int f = 0; f < 4; f++)
    begin
      apb(1, {CTRL_IDX + 11'h5, 2'h0}, 32'h40 | (f << 2));
      send(5, 4'hC, 0);
      chk("pcm abcd", exp[f], rx_pcm_serial_out_abcd);
      chk("pcm octet", 8'hA0, rx_pcm_serial_out);
    end
    send(6, 4'hC, 0);
    chk("other ts abcd", 4'hC, rx_pcm_serial_out_abcd);
    apb(1, {CTRL_IDX + 11'h5, 2'h0}, 32'h0C);
    send(5, 4'hC, 0);
    chk("subst off", 4'hC, rx_pcm_serial_out_abcd);
  endtask
  task automatic t_extract();
    logic [3:0] exp [4] = '{4'h0, 4'hD, 4'hC, 4'h8};
    int n;
    apb(1, {GLOBAL_IDX, 2'h0}, 32'h01);
    for (int e = 1; e < 4; e++)
    begin
      apb(1, {CTRL_IDX + 11'h9, 2'h0}, 32'h60 | e);
      send(9, 4'hD, 1);
      chk("pcm ones", 4'hF, rx_pcm_serial_out_abcd);
      settle();
      chk("oh pin", exp[e], bp.oh_val);
      chk("oh ts", 9, bp.oh_ts);
      chk("sig pin", exp[e], bp.sig_val);
      apb(0, {ARRAY_IDX + 11'h9, 2'h0}, 0);
      chk("array", exp[e], rd);
    end
    n = bp.oh_cnt;
    apb(1, {CTRL_IDX + 11'h9, 2'h0}, 32'h60);
    send(9, 4'hA, 1);
    settle();
    chk("oh count", n, bp.oh_cnt);
    apb(0, {ARRAY_IDX + 11'h9, 2'h0}, 0);
    chk("array kept", 8, rd);
  endtask
  task automatic t_debounce();
    int n;
    n = bp.sig_cnt;
    apb(1, {CTRL_IDX + 11'hC, 2'h0}, 32'h11);
    send(12, 4'h3, 1);
    settle();
    apb(0, {ARRAY_IDX + 11'hC, 2'h0}, 0);
    chk("debounce first", 0, rd);
    chk("debounce pin held", n, bp.sig_cnt);
    send(12, 4'h3, 1);
    settle();
    apb(0, {ARRAY_IDX + 11'hC, 2'h0}, 0);
    chk("debounce second", 3, rd);
    chk("debounce pin", 3, bp.sig_val);
    chk("sig ts", 12, bp.sig_ts);
    apb(1, {GLOBAL_IDX, 2'h0}, 32'h00);
    apb(1, {CTRL_IDX + 11'hC, 2'h0}, 32'h01);
    n = bp.sig_cnt;
    send(12, 4'h6, 1);
    settle();
    apb(0, {ARRAY_IDX + 11'hC, 2'h0}, 0);
    chk("array no debounce", 6, rd);
    chk("sig interface off", n, bp.sig_cnt);
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_subst();
    t_extract();
    t_debounce();
    end_of_test();
  end
endmodule
`default_nettype wire
